//--- include/pte_map.vh
`ifndef PTE_MAP_VH
`define PTE_MAP_VH
// Register offsets
`define PTE_OFS_ENABLE   8'h00
`define PTE_OFS_CTRL     8'h02
`define PTE_OFS_CMD      8'h04
`define PTE_OFS_EVA      8'h08
`define PTE_OFS_EVB      8'h09
`define PTE_OFS_IEN      8'h0C
`define PTE_OFS_IFL      8'h0D
`define PTE_OFS_STAT     8'h0E
`define PTE_OFS_CMPBH    8'h0F
`define PTE_OFS_MODEA    8'h10
`define PTE_OFS_MODEB    8'h11
`define PTE_OFS_DBG      8'h1E
// Event configuration fields
`define PTE_EV_TRIG      0
`define PTE_EV_ACTION    2
`define PTE_EV_EDGE      4
`define PTE_EV_CFG_HI    7
`define PTE_EV_CFG_LO    6
`define PTE_EV_WMASK     8'hD5
`define PTE_CFG_NONE     2'h0
`define PTE_CFG_FILTER   2'h1
`define PTE_CFG_ASYNC    2'h2
`define PTE_FILT_LAST    3'h3
// Flag and enable bits
`define PTE_IRQ_B        3
`define PTE_IRQ_A        2
`define PTE_IRQ_OVF      0
`define PTE_IRQ_MASK     8'h0D
// Status bits
`define PTE_ST_ACTB      7
`define PTE_ST_ACTA      6
`define PTE_ST_COMMAND_READY    1
`define PTE_ST_ENABLE_READY     0
`define PTE_ST_W1C_MASK  8'hC0
// Command strobe bits
`define PTE_CMD_SYNC_AT_CYCLE_END_STROBE  0
`define PTE_CMD_SYNC     1
`define PTE_CMD_RESTART  2
`define PTE_CMD_SCAPA    3
`define PTE_CMD_SCAPB    4
`define PTE_CMD_DISABLE_AT_CYCLE_END   7
`define PTE_CMD_MASK     8'h1F
// Control bits
`define PTE_CTRL_AUTO    1
`define PTE_DBG_RUN      0
`define PTE_EN_BIT       0
// Fault input modes
`define PTE_MODE_NONE    4'h0
`define PTE_MODE_JMPW    4'h1
`define PTE_MODE_EXECF   4'h3
`define PTE_MODE_STOP_ALL_KEEP_PERIOD    4'h4
`define PTE_MODE_STOP_ALL_WAIT_SOFTWARE  4'h7
`define PTE_MODE_EDGE    4'h8
`define PTE_MODE_EDGEF   4'h9
`define PTE_MODE_LVLF    4'hA
`define PTE_SYNC_CYCLES  4'h3
`endif

//--- core/pte_core.v
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "pte_map.vh"
`default_nettype none

module pte_core #(
	parameter [3:0] SYNC_CYCLES = `PTE_SYNC_CYCLES
) (
	input  wire       clock,
	input  wire       rst,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_write,
	input  wire       reg_read,
	output reg  [7:0] reg_rdata,
	input  wire       event_in_a,
	input  wire       event_in_b,
	input  wire       waveform_out_a,
	input  wire       waveform_out_b,
	input  wire       cycle_end,
	input  wire       debug_break,
	output reg        fault_level_a,
	output reg        fault_level_b,
	output reg        trigger_a,
	output reg        trigger_b,
	output reg        capture_a,
	output reg        capture_b,
	output reg  [3:0] fault_mode_a,
	output reg  [3:0] fault_mode_b,
	output reg        stop_all_a,
	output reg        stop_all_b,
	output reg  [4:0] timer_cmd,
	output reg        timer_enable,
	output reg        irq_request
);

	// Reserved fault mode codes drive the fault mode outputs as no action
	function [3:0] mode_clean;
		input [3:0] m;
		begin
			if (m > `PTE_MODE_LVLF) begin
				mode_clean = `PTE_MODE_NONE;
			end else begin
				mode_clean = m;
			end
		end
	endfunction

	// Modes that stop every output
	function is_stop_all;
		input [3:0] m;
		begin
			is_stop_all = (m >= `PTE_MODE_STOP_ALL_KEEP_PERIOD) &&
				(m <= `PTE_MODE_STOP_ALL_WAIT_SOFTWARE);
		end
	endfunction

	wire wr_hit = reg_write;

	reg  [7:0] ev_cfg_a_q;
	reg  [7:0] ev_cfg_b_q;
	reg  [7:0] irq_en_q;
	reg  [7:0] irq_flag_q;
	reg        act_a_q;
	reg        act_b_q;
	reg  [3:0] mode_a_q;
	reg  [3:0] mode_b_q;
	reg        auto_update_q;
	reg        run_in_debug_q;
	reg        enable_q;

	reg  [1:0] ev_s1_q;
	reg  [1:0] ev_s2_q;
	reg  [1:0] ev_s3_q;
	reg  [1:0] ev_lvl_q;
	reg  [1:0] ev_filt_q;
	reg  [5:0] filt_cnt_q;
	reg  [1:0] ev_raw_q;
	reg  [1:0] ev_prev_q;
	reg        brk_s1_q;
	reg        brk_s2_q;
	reg        brk_s3_q;
	reg        brk_lvl_q;
	reg        wo_a_prev_q;
	reg        wo_b_prev_q;

	reg  [3:0] cmd_cnt_q;
	reg  [4:0] cmd_pend_q;
	reg        command_ready_q;
	reg  [3:0] en_cnt_q;
	reg        disable_at_cycle_end_pend_q;
	reg        enable_ready_q;

	reg  [1:0] ev_sel;
	reg  [1:0] ev_act;
	reg  [1:0] ev_fire;
	reg  [1:0] ev_cfg_mode;
	reg  [7:0] cfg_now;
	integer    i;
	integer    j;

	wire halted = brk_lvl_q & ~run_in_debug_q;
	wire brk_enter = brk_s2_q & brk_s3_q & ~brk_lvl_q & ~run_in_debug_q;

	// Event source selection per channel
	always @* begin
		ev_sel = 2'h0;
		ev_act = 2'h0;
		ev_fire = 2'h0;
		ev_cfg_mode = 2'h0;
		cfg_now = 8'h00;
		for (i = 0; i < 2; i = i + 1) begin
			cfg_now = (i == 0) ? ev_cfg_a_q : ev_cfg_b_q;
			ev_cfg_mode = cfg_now[`PTE_EV_CFG_HI:`PTE_EV_CFG_LO];
			case (ev_cfg_mode)
				`PTE_CFG_FILTER: ev_sel[i] = ev_filt_q[i];
				`PTE_CFG_ASYNC:  ev_sel[i] = ev_raw_q[i];
				`PTE_CFG_NONE:   ev_sel[i] = ev_lvl_q[i];
				default:         ev_sel[i] = ev_lvl_q[i];
			endcase
			ev_act[i] = ~(ev_sel[i] ^ cfg_now[`PTE_EV_EDGE]);
			ev_fire[i] = ev_act[i] & ~ev_prev_q[i] & ~halted &
				cfg_now[`PTE_EV_TRIG];
		end
	end

	// Input synchronisers and noise filter
	always @(posedge clock) begin
		if (rst) begin
			ev_s1_q <= 2'h0;
			ev_s2_q <= 2'h0;
			ev_s3_q <= 2'h0;
			ev_lvl_q <= 2'h0;
			ev_filt_q <= 2'h0;
			filt_cnt_q <= 6'h00;
			ev_raw_q <= 2'h0;
			brk_s1_q <= 1'b0;
			brk_s2_q <= 1'b0;
			brk_s3_q <= 1'b0;
			brk_lvl_q <= 1'b0;
		end else begin
			ev_s1_q <= {event_in_b, event_in_a};
			ev_s2_q <= ev_s1_q;
			ev_s3_q <= ev_s2_q;
			ev_raw_q <= {event_in_b, event_in_a};
			brk_s1_q <= debug_break;
			brk_s2_q <= brk_s1_q;
			brk_s3_q <= brk_s2_q;
			if (brk_s2_q == brk_s3_q) begin
				brk_lvl_q <= brk_s3_q;
			end
			for (j = 0; j < 2; j = j + 1) begin
				if (ev_s2_q[j] == ev_s3_q[j]) begin
					ev_lvl_q[j] <= ev_s3_q[j];
				end
				if (ev_lvl_q[j] == ev_filt_q[j]) begin
					filt_cnt_q[j*3 +: 3] <= 3'h0;
				end else if (filt_cnt_q[j*3 +: 3] == `PTE_FILT_LAST) begin
					ev_filt_q[j] <= ev_lvl_q[j];
					filt_cnt_q[j*3 +: 3] <= 3'h0;
				end else begin
					filt_cnt_q[j*3 +: 3] <= filt_cnt_q[j*3 +: 3] + 3'h1;
				end
			end
		end
	end

	// Trigger, capture and fault outputs
	always @(posedge clock) begin
		if (rst) begin
			ev_prev_q <= 2'h0;
			trigger_a <= 1'b0;
			trigger_b <= 1'b0;
			capture_a <= 1'b0;
			capture_b <= 1'b0;
			fault_level_a <= 1'b0;
			fault_level_b <= 1'b0;
			fault_mode_a <= 4'h0;
			fault_mode_b <= 4'h0;
			stop_all_a <= 1'b0;
			stop_all_b <= 1'b0;
		end else begin
			ev_prev_q <= ev_act;
			trigger_a <= ev_fire[0];
			trigger_b <= ev_fire[1];
			capture_a <= ev_fire[0] & ev_cfg_a_q[`PTE_EV_ACTION];
			capture_b <= ev_fire[1] & ev_cfg_b_q[`PTE_EV_ACTION];
			fault_level_a <= ev_act[0] & ev_cfg_a_q[`PTE_EV_TRIG] & ~halted;
			fault_level_b <= ev_act[1] & ev_cfg_b_q[`PTE_EV_TRIG] & ~halted;
			fault_mode_a <= mode_clean(mode_a_q);
			fault_mode_b <= mode_clean(mode_b_q);
			stop_all_a <= is_stop_all(mode_a_q);
			stop_all_b <= is_stop_all(mode_b_q);
		end
	end

	// Configuration registers
	always @(posedge clock) begin
		if (rst) begin
			ev_cfg_a_q <= 8'h00;
			ev_cfg_b_q <= 8'h00;
			irq_en_q <= 8'h00;
			mode_a_q <= 4'h0;
			mode_b_q <= 4'h0;
			auto_update_q <= 1'b0;
			run_in_debug_q <= 1'b0;
		end else if (wr_hit) begin
			case (reg_addr)
				`PTE_OFS_EVA:   ev_cfg_a_q <= reg_wdata & `PTE_EV_WMASK;
				`PTE_OFS_EVB:   ev_cfg_b_q <= reg_wdata & `PTE_EV_WMASK;
				`PTE_OFS_IEN:   irq_en_q <= reg_wdata & `PTE_IRQ_MASK;
				`PTE_OFS_MODEA: mode_a_q <= reg_wdata[3:0];
				`PTE_OFS_MODEB: mode_b_q <= reg_wdata[3:0];
				`PTE_OFS_CTRL:  auto_update_q <= reg_wdata[`PTE_CTRL_AUTO];
				`PTE_OFS_DBG:   run_in_debug_q <= reg_wdata[`PTE_DBG_RUN];
				default: begin
				end
			endcase
		end
	end

	wire flag_wr = wr_hit && (reg_addr == `PTE_OFS_IFL);
	wire stat_wr = wr_hit && (reg_addr == `PTE_OFS_STAT);

	// Sticky flags, set beats clear
	always @(posedge clock) begin
		if (rst) begin
			irq_flag_q <= 8'h00;
			act_a_q <= 1'b0;
			act_b_q <= 1'b0;
			wo_a_prev_q <= 1'b0;
			wo_b_prev_q <= 1'b0;
			irq_request <= 1'b0;
		end else begin
			wo_a_prev_q <= waveform_out_a;
			wo_b_prev_q <= waveform_out_b;
			if (ev_fire[1]) begin
				irq_flag_q[`PTE_IRQ_B] <= 1'b1;
			end else if (flag_wr && reg_wdata[`PTE_IRQ_B]) begin
				irq_flag_q[`PTE_IRQ_B] <= 1'b0;
			end
			if (ev_fire[0]) begin
				irq_flag_q[`PTE_IRQ_A] <= 1'b1;
			end else if (flag_wr && reg_wdata[`PTE_IRQ_A]) begin
				irq_flag_q[`PTE_IRQ_A] <= 1'b0;
			end
			if (cycle_end) begin
				irq_flag_q[`PTE_IRQ_OVF] <= 1'b1;
			end else if (flag_wr && reg_wdata[`PTE_IRQ_OVF]) begin
				irq_flag_q[`PTE_IRQ_OVF] <= 1'b0;
			end
			if (waveform_out_b != wo_b_prev_q) begin
				act_b_q <= 1'b1;
			end else if (stat_wr && reg_wdata[`PTE_ST_ACTB]) begin
				act_b_q <= 1'b0;
			end
			if (waveform_out_a != wo_a_prev_q) begin
				act_a_q <= 1'b1;
			end else if (stat_wr && reg_wdata[`PTE_ST_ACTA]) begin
				act_a_q <= 1'b0;
			end
			irq_request <= |(irq_flag_q & irq_en_q);
		end
	end

	wire cmd_wr = wr_hit && (reg_addr == `PTE_OFS_CMD);
	wire cmpbh_wr = wr_hit && (reg_addr == `PTE_OFS_CMPBH);
	wire en_wr = wr_hit && (reg_addr == `PTE_OFS_ENABLE);
	wire [4:0] cmd_bits = reg_wdata[4:0];
	wire cmd_start = command_ready_q &&
		((cmd_wr && (|cmd_bits)) || (cmpbh_wr && auto_update_q));
	wire disable_at_cycle_end_req = cmd_wr && reg_wdata[`PTE_CMD_DISABLE_AT_CYCLE_END] &&
		enable_ready_q && enable_q;
	wire disable_at_cycle_end_done = disable_at_cycle_end_pend_q && cycle_end;

	// Command crossing into the timer side
	always @(posedge clock) begin
		if (rst) begin
			cmd_cnt_q <= SYNC_CYCLES;
			cmd_pend_q <= 5'h00;
			command_ready_q <= 1'b0;
			timer_cmd <= 5'h00;
		end else begin
			timer_cmd <= 5'h00;
			if (cmd_start) begin
				cmd_cnt_q <= SYNC_CYCLES;
				command_ready_q <= 1'b0;
				if (cmd_wr) begin
					cmd_pend_q <= cmd_bits;
				end else begin
					cmd_pend_q <= 5'h01;
				end
			end else if (cmd_cnt_q != 4'h0) begin
				cmd_cnt_q <= cmd_cnt_q - 4'h1;
			end else if (!command_ready_q) begin
				timer_cmd <= cmd_pend_q;
				cmd_pend_q <= 5'h00;
				command_ready_q <= 1'b1;
			end
		end
	end

	// Enable crossing into the timer side
	always @(posedge clock) begin
		if (rst) begin
			enable_q <= 1'b0;
			en_cnt_q <= SYNC_CYCLES;
			disable_at_cycle_end_pend_q <= 1'b0;
			enable_ready_q <= 1'b0;
			timer_enable <= 1'b0;
		end else begin
			if (en_wr && enable_ready_q) begin
				enable_q <= reg_wdata[`PTE_EN_BIT];
				en_cnt_q <= SYNC_CYCLES;
				enable_ready_q <= 1'b0;
			end else if (disable_at_cycle_end_req) begin
				disable_at_cycle_end_pend_q <= 1'b1;
				enable_ready_q <= 1'b0;
			end else if (disable_at_cycle_end_done) begin
				disable_at_cycle_end_pend_q <= 1'b0;
				enable_q <= 1'b0;
				timer_enable <= 1'b0;
				en_cnt_q <= SYNC_CYCLES;
			end else if (brk_enter || halted) begin
				en_cnt_q <= SYNC_CYCLES;
				enable_ready_q <= 1'b0;
			end else if (disable_at_cycle_end_pend_q) begin
				enable_ready_q <= 1'b0;
			end else if (en_cnt_q != 4'h0) begin
				en_cnt_q <= en_cnt_q - 4'h1;
			end else begin
				timer_enable <= enable_q;
				enable_ready_q <= 1'b1;
			end
		end
	end

	// Read port, data one cycle after strobe
	always @(posedge clock) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
				`PTE_OFS_ENABLE: reg_rdata <= {7'h00, enable_q};
				`PTE_OFS_CTRL:   reg_rdata <= {6'h00, auto_update_q, 1'b0};
				`PTE_OFS_EVA:    reg_rdata <= ev_cfg_a_q;
				`PTE_OFS_EVB:    reg_rdata <= ev_cfg_b_q;
				`PTE_OFS_IEN:    reg_rdata <= irq_en_q;
				`PTE_OFS_IFL:    reg_rdata <= irq_flag_q;
				`PTE_OFS_STAT:   reg_rdata <= {act_b_q, act_a_q, 4'h0,
					command_ready_q, enable_ready_q};
				`PTE_OFS_MODEA:  reg_rdata <= {4'h0, mode_a_q};
				`PTE_OFS_MODEB:  reg_rdata <= {4'h0, mode_b_q};
				`PTE_OFS_DBG:    reg_rdata <= {7'h00, run_in_debug_q};
				default:         reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule // pte_core

`default_nettype wire

//--- verification/pte_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pte_core_chk (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       trigger_a,
	input wire logic       trigger_b,
	input wire logic       capture_a,
	input wire logic       capture_b,
	input wire logic [3:0] fault_mode_a,
	input wire logic [3:0] fault_mode_b,
	input wire logic       stop_all_a,
	input wire logic       stop_all_b,
	input wire logic [4:0] timer_cmd
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	property p_ev_read;
		reg_read && reg_addr[7:1] == 7'h04 |=> (reg_rdata & 8'h2A) == 8'h00;
	endproperty
	a_ev_read: assert property (p_ev_read) else $error("ev bits");
	property p_cap_a;
		capture_a |-> trigger_a;
	endproperty
	a_cap_a: assert property (p_cap_a) else $error("cap a");
	property p_cap_b;
		capture_b |-> trigger_b;
	endproperty
	a_cap_b: assert property (p_cap_b) else $error("cap b");
	property p_trig_pulse;
		trigger_a |=> !trigger_a;
	endproperty
	a_trig_pulse: assert property (p_trig_pulse) else $error("trig");
	property p_stop_a;
		stop_all_a == (fault_mode_a[3:2] == 2'b01);
	endproperty
	a_stop_a: assert property (p_stop_a) else $error("stop a");
	property p_stop_b;
		stop_all_b == (fault_mode_b[3:2] == 2'b01);
	endproperty
	a_stop_b: assert property (p_stop_b) else $error("stop b");
	property p_mode_max;
		fault_mode_a <= 4'hA && fault_mode_b <= 4'hA;
	endproperty
	a_mode_max: assert property (p_mode_max) else $error("mode");
	property p_cmd_gap;
		timer_cmd != 5'h00 |=> (timer_cmd == 5'h00) [*2];
	endproperty
	a_cmd_gap: assert property (p_cmd_gap) else $error("cmd");
endmodule // pte_core_chk
bind pte_core pte_core_chk i_chk (
	.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .trigger_a(trigger_a), .trigger_b(trigger_b),
	.capture_a(capture_a), .capture_b(capture_b),
	.fault_mode_a(fault_mode_a), .fault_mode_b(fault_mode_b),
	.stop_all_a(stop_all_a), .stop_all_b(stop_all_b), .timer_cmd(timer_cmd)
);
`default_nettype wire

//--- verification/pte_evt_src.sv
`timescale 1ns/1ps
`default_nettype none
module pte_evt_src (
	input  wire logic clock,
	output var logic  event_a,
	output var logic  event_b
);
	initial begin
		event_a = 1'b0;
		event_b = 1'b0;
	end
	// Level change just after an edge, held until the next call
	task automatic set(input int ch, input logic v);
		@(posedge clock);
		if (ch == 0)
			event_a <= v;
		else
			event_b <= v;
	endtask
endmodule // pte_evt_src
`default_nettype wire

//--- verification/pte_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       clock;
	logic       rst;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_write;
	logic       reg_read;
	logic [7:0] reg_rdata;
	logic       ev_a;
	logic       ev_b;
	logic       wave_a;
	logic       wave_b;
	logic       cycle_end;
	logic       dbg;
	logic       fault_level_a;
	logic       fault_level_b;
	logic       trigger_a;
	logic       trigger_b;
	logic       capture_a;
	logic       capture_b;
	logic [3:0] fault_mode_a;
	logic [3:0] fault_mode_b;
	logic       stop_all_a;
	logic       stop_all_b;
	logic [4:0] timer_cmd;
	logic       timer_enable;
	logic       irq_request;
	int         failures;
	int         n_compared;
	int         n_trig_b = 0;
	int         lat [0:3];
	int         n;
	logic [7:0] rv [0:7] = '{8'h08, 8'h09, 8'h0C, 8'h0D, 8'h10, 8'h11,
		8'h04, 8'h05};
	pte_core i_dut (
		.clock(clock), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .event_in_a(ev_a), .event_in_b(ev_b),
		.waveform_out_a(wave_a), .waveform_out_b(wave_b),
		.cycle_end(cycle_end), .debug_break(dbg),
		.fault_level_a(fault_level_a), .fault_level_b(fault_level_b),
		.trigger_a(trigger_a), .trigger_b(trigger_b),
		.capture_a(capture_a), .capture_b(capture_b),
		.fault_mode_a(fault_mode_a), .fault_mode_b(fault_mode_b),
		.stop_all_a(stop_all_a), .stop_all_b(stop_all_b),
		.timer_cmd(timer_cmd), .timer_enable(timer_enable),
		.irq_request(irq_request)
	);
	pte_evt_src i_src (.clock(clock), .event_a(ev_a), .event_b(ev_b));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock)
		if (trigger_b === 1'b1)
			n_trig_b <= n_trig_b + 1;
	task automatic end_sim();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		chk($sformatf("reg %h", a), e, reg_rdata);
	endtask
	function automatic logic hit(input int s);
		case (s)
			0: return trigger_a === 1'b1;
			1: return trigger_b === 1'b1;
			2: return (|timer_cmd) === 1'b1;
			default: return timer_enable === 1'b1;
		endcase
	endfunction
	task automatic wait_for(input int s, output int k);
		k = 0;
		@(negedge clock);
		while (!hit(s)) begin
			@(negedge clock);
			k++;
			if (k > 60) begin
				failures++;
				$display("[ERR] wait %0d expected hit seen none", s);
				end_sim();
			end
		end
	endtask
	initial begin
		failures = 0;
		n_compared = 0;
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		wave_a = 1'b0;
		wave_b = 1'b0;
		cycle_end = 1'b0;
		dbg = 1'b0;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		foreach (rv[i]) rc(rv[i], 8'h00);
		rc(8'h0E, 8'h03);
		wr(8'h08, 8'hFF);
		rc(8'h08, 8'hD5);
		wr(8'h09, 8'hFF);
		rc(8'h09, 8'hD5);
		wr(8'h0C, 8'hFF);
		rc(8'h0C, 8'h0D);
		for (int m = 0; m < 16; m++) begin
			wr(8'h10, m[7:0]);
			wr(8'h11, 8'(15 - m));
			rc(8'h10, m[7:0]);
			chk("mode a", (m > 10) ? 8'h00 : 8'(m), 8'(fault_mode_a));
			chk("mode b", (m < 5) ? 8'h00 : 8'(15 - m), 8'(fault_mode_b));
			chk("stop a", 8'(m >= 4 && m <= 7), 8'(stop_all_a));
		end
		wr(8'h0C, 8'h04);
		wr(8'h08, 8'h15);
		i_src.set(0, 1'b1);
		wait_for(0, n);
		chk("capture a", 8'h01, 8'(capture_a));
		rc(8'h0D, 8'h04);
		chk("irq", 8'h01, 8'(irq_request));
		wr(8'h0D, 8'h04);
		rc(8'h0D, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(8'h09, {c[1:0], 6'h15});
			repeat (12) @(posedge clock);
			i_src.set(1, 1'b1);
			wait_for(1, lat[c]);
			chk("capture b", 8'h01, 8'(capture_b));
			i_src.set(1, 1'b0);
		end
		chk("filter lag", 8'(lat[0] + 4), 8'(lat[1]));
		chk("reserved cfg", 8'(lat[0]), 8'(lat[3]));
		chk("async", 8'h01, 8'(lat[2] < lat[0]));
		wr(8'h09, 8'h51);
		repeat (12) @(posedge clock);
		n = n_trig_b;
		i_src.set(1, 1'b1);
		repeat (2) @(posedge clock);
		i_src.set(1, 1'b0);
		repeat (12) @(posedge clock);
		chk("glitch", 8'(n), 8'(n_trig_b));
		wr(8'h09, 8'h00);
		i_src.set(1, 1'b1);
		repeat (12) @(posedge clock);
		wr(8'h09, 8'h01);
		repeat (12) @(posedge clock);
		i_src.set(1, 1'b0);
		wait_for(1, n);
		repeat (2) @(posedge clock);
		n = n_trig_b;
		i_src.set(1, 1'b1);
		repeat (12) @(posedge clock);
		chk("rise ignored", 8'(n), 8'(n_trig_b));
		chk("irq masked", 8'h00, 8'(irq_request));
		@(posedge clock);
		cycle_end <= 1'b1;
		@(posedge clock);
		cycle_end <= 1'b0;
		rc(8'h0D, 8'h09);
		wr(8'h0D, 8'h09);
		rc(8'h0D, 8'h00);
		@(posedge clock);
		wave_a <= 1'b1;
		rc(8'h0E, 8'h43);
		wr(8'h0E, 8'h40);
		rc(8'h0E, 8'h03);
		@(posedge clock);
		wave_b <= 1'b1;
		rc(8'h0E, 8'h83);
		wr(8'h0E, 8'h80);
		for (int i = 0; i < 5; i++) begin
			wr(8'h04, 8'h01 << i);
			rc(8'h0E, 8'h01);
			wr(8'h04, 8'h1F);
			wait_for(2, n);
			chk("command", 8'h01 << i, 8'(timer_cmd));
		end
		wr(8'h02, 8'h02);
		wr(8'h0F, 8'h55);
		wait_for(2, n);
		chk("auto update", 8'h01, 8'(timer_cmd));
		wr(8'h00, 8'h01);
		rc(8'h0E, 8'h02);
		wait_for(3, n);
		rc(8'h0E, 8'h03);
		chk("fault a", 8'h01, 8'(fault_level_a));
		chk("fault b", 8'h00, 8'(fault_level_b));
		@(posedge clock);
		dbg <= 1'b1;
		repeat (8) @(posedge clock);
		rc(8'h0E, 8'h02);
		chk("halt fault a", 8'h00, 8'(fault_level_a));
		n = n_trig_b;
		i_src.set(1, 1'b0);
		repeat (10) @(posedge clock);
		chk("halt trig", 8'(n), 8'(n_trig_b));
		chk("halt fault b", 8'h00, 8'(fault_level_b));
		@(posedge clock);
		dbg <= 1'b0;
		repeat (12) @(posedge clock);
		rc(8'h0E, 8'h03);
		chk("fault b", 8'h01, 8'(fault_level_b));
		wr(8'h1E, 8'h01);
		@(posedge clock);
		dbg <= 1'b1;
		repeat (8) @(posedge clock);
		rc(8'h0E, 8'h03);
		@(posedge clock);
		dbg <= 1'b0;
		wr(8'h04, 8'h80);
		rc(8'h0E, 8'h02);
		@(posedge clock);
		cycle_end <= 1'b1;
		@(posedge clock);
		cycle_end <= 1'b0;
		repeat (8) @(posedge clock);
		rc(8'h0E, 8'h03);
		rc(8'h00, 8'h00);
		chk("timer enable", 8'h00, 8'(timer_enable));
		end_sim();
	end
endmodule // testbench
`default_nettype wire
